// file: rtl/qss_pkg.sv
// Package of constants and types for the quad switch serial control block
package qss_pkg;

  // ==========================================================================
  // Serial frame layout
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_COUNT = 5'h10;
  localparam int WD_BIT = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 10;

  // ==========================================================================
  // Serial register addresses
  localparam logic [4:0] SA_OUT_ON = 5'h00;
  localparam logic [4:0] SA_DIR_DIS = 5'h01;
  localparam logic [4:0] SA_SENSE = 5'h02;
  localparam logic [4:0] SA_CONTROL = 5'h03;
  localparam logic [4:0] SA_DUTY = 5'h04;

  // Field positions
  localparam int SENSE_HIZ_BIT = 3;
  localparam int SENSE_TEMP_BIT = 2;
  localparam int CTRL_VDD_EN_BIT = 0;
  localparam int CTRL_PWM_EN_BIT = 1;

  // Status word positions
  localparam int ST_NORMAL = 15;
  localparam int ST_FAILSAFE = 14;
  localparam int ST_WD_EN = 13;
  localparam int ST_VDD_FAIL = 12;
  localparam int ST_FAULT_LO = 8;
  localparam int ST_DIRECT_LO = 4;
  localparam int ST_LAMP_LO = 0;

  // ==========================================================================
  // Bus register byte offsets
  localparam logic [7:0] RA_STATUS = 8'h00;
  localparam logic [7:0] RA_FAULT_MASK = 8'h04;
  localparam logic [7:0] RA_LAST_CMD = 8'h08;
  localparam logic [7:0] RA_MIRROR = 8'h80;

  // Reset values
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [6:0] RST_DUTY = 7'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [3:0] RST_FAULT_MASK = 4'h0;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int WDT_TIME_MS = 310;
  localparam int WDT_CYCLES = WDT_TIME_MS * 1000 * CLK_MHZ;

  // Operating modes
  typedef enum logic [1:0] {
    QSS_SLEEP = 2'b00,
    QSS_NORMAL = 2'b01,
    QSS_FAILSAFE = 2'b10
  } qss_mode_t;

endpackage : qss_pkg

// file: rtl/qss_mirror_mem.sv
// Small memory that mirrors every serial word by its address
`timescale 1ns/100ps
module qss_mirror_mem
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [15:0] wr_data,
  // Read port
  input wire logic [4:0] rd_addr,
  output logic [15:0] rd_data
);

  logic [15:0] mem [0:31];
  logic [15:0] next_rd_data;

  // ==========================================================================
  // Registered read, no reset on the array to keep it a plain RAM
  always_comb
  begin
    next_rd_data = rst_n ? mem[rd_addr] : qss_pkg::RST_WORD;
  end

  always_ff @(posedge mclk)
  begin
    rd_data <= next_rd_data;
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

endmodule : qss_mirror_mem

// file: rtl/qss_spi_ctrl.sv
// Serial control port, direct pins, watchdog and bus registers of a quad lamp switch
// Notes on behaviour
// - Sample serial input on falling clock edge
// - Shift serial output on rising clock edge
// - Select rise writes received word to register
// - Select fall loads status into output shifter
// - Output driven only while select low
// - Five-bit address field picks the register
// - Fault flag pulled low on any unmasked fault
// - Direct inputs, wake, init all wake device
// - Direct input n drives lamp n
// - Input zero is the external PWM clock
// - Init low clears config and faults, sleeps
// - Init rising edge starts the watchdog
// - Strap high enables watchdog, low disables
// - Watchdog timeout: lamps follow direct inputs
// - Enabled supply loss enters fail-safe mode
// - Configurable sense source or high impedance
// - Normal mode lamps follow serial commands
// - Fail-safe: direct control, configuration defaults except supply enable
// - Shifted-out word is status at frame start
// - Toggle watchdog bit within timeout
// - Exit fail-safe with bit set, clear faults
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module qss_spi_ctrl
#(
  parameter int WDT_COUNT = qss_pkg::WDT_CYCLES
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Serial link
  input wire logic sclk,
  input wire logic select_n,
  input wire logic si,
  output logic so_out,
  output logic so_oe,
  // Control pins
  input wire logic init_n,
  input wire logic wake,
  input wire logic failsafe_strap,
  input wire logic vdd_fail,
  input wire logic [3:0] direct_inputs,
  input wire logic [3:0] fault_in,
  // Outputs
  output logic [3:0] lamp_outputs,
  output logic fault_flag_n_out,
  output logic fault_flag_n_oe,
  output logic [1:0] sense_channel,
  output logic sense_temp,
  output logic sense_output_oe
);

  // ==========================================================================
  // Pin synchronisers
  localparam int NSYNC = 15;
  logic [NSYNC-1:0] pins;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync3;

  assign pins = {sclk, select_n, si, init_n, wake, failsafe_strap, vdd_fail,
                 direct_inputs, fault_in};

  // Two stages before use; third stage only for edge finding
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sync1 <= pins;
      sync2 <= pins;
      sync3 <= pins;
    end
    else
    begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  logic s_sclk, s_sel_n, s_si, s_init, s_wake, s_strap, s_vdd;
  logic [3:0] s_dir;
  logic [3:0] s_fault;
  logic p_sclk, p_sel_n, p_init, p_wake;
  logic [3:0] p_dir;

  assign {s_sclk, s_sel_n, s_si, s_init, s_wake, s_strap, s_vdd, s_dir, s_fault} = sync2;
  assign p_sclk = sync3[14];
  assign p_sel_n = sync3[13];
  assign p_init = sync3[11];
  assign p_wake = sync3[10];
  assign p_dir = sync3[7:4];

  logic sclk_rise, sclk_fall, sel_fall, sel_rise;
  // Clock edges count only inside a frame; outside it they are ignored
  assign sclk_rise = s_sclk & ~p_sclk & ~s_sel_n;
  assign sclk_fall = ~s_sclk & p_sclk & ~s_sel_n;
  assign sel_fall = ~s_sel_n & p_sel_n;
  assign sel_rise = s_sel_n & ~p_sel_n;

  // ==========================================================================
  // Serial shifters
  logic [15:0] tx_shift, next_tx_shift;
  logic [15:0] rx_shift, next_rx_shift;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [15:0] last_cmd, next_last_cmd;
  logic cmd_valid, next_cmd_valid;
  logic next_so_out, next_so_oe;
  logic [15:0] status_word;

  // Frame handling; status snapshot taken at select fall, word kept at select rise
  always_comb
  begin
    next_tx_shift = tx_shift;
    next_rx_shift = rx_shift;
    next_bit_cnt = bit_cnt;
    next_last_cmd = last_cmd;
    next_cmd_valid = 1'b0;
    if (sel_fall)
    begin
      next_tx_shift = status_word;
      next_bit_cnt = 5'h00;
    end
    else if (sclk_rise && bit_cnt != 5'h00)
    begin
      next_tx_shift = {tx_shift[14:0], 1'b0};
    end
    if (sclk_fall)
    begin
      next_rx_shift = {rx_shift[14:0], s_si};
      if (bit_cnt != 5'h1F)
      begin
        next_bit_cnt = bit_cnt + 5'h01;
      end
    end
    // Short or long frames are dropped rather than half applied
    if (sel_rise && bit_cnt == qss_pkg::FRAME_COUNT)
    begin
      next_last_cmd = rx_shift;
      next_cmd_valid = 1'b1;
    end
    next_so_out = next_tx_shift[15];
    next_so_oe = ~s_sel_n;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tx_shift <= qss_pkg::RST_WORD;
      rx_shift <= qss_pkg::RST_WORD;
      bit_cnt <= 5'h00;
      last_cmd <= qss_pkg::RST_WORD;
      cmd_valid <= 1'b0;
      so_out <= 1'b0;
      so_oe <= 1'b0;
    end
    else
    begin
      tx_shift <= next_tx_shift;
      rx_shift <= next_rx_shift;
      bit_cnt <= next_bit_cnt;
      last_cmd <= next_last_cmd;
      cmd_valid <= next_cmd_valid;
      so_out <= next_so_out;
      so_oe <= next_so_oe;
    end
  end

  // ==========================================================================
  // Mode, configuration, watchdog and faults
  qss_pkg::qss_mode_t mode, next_mode;
  logic [3:0] on_bits, next_on_bits;
  logic [3:0] dir_dis, next_dir_dis;
  logic [3:0] sense_cfg, next_sense_cfg;
  logic vdd_en, next_vdd_en;
  logic pwm_en, next_pwm_en;
  logic [6:0] duty, next_duty;
  logic [6:0] pwm_cnt, next_pwm_cnt;
  logic wd_last, next_wd_last;
  logic wd_run, next_wd_run;
  logic wd_fired, next_wd_fired;
  logic [31:0] wd_cnt, next_wd_cnt;
  logic [3:0] fault_lat, next_fault_lat;
  logic [3:0] next_lamps;
  logic [3:0] fault_mask;
  logic [4:0] cmd_addr;
  logic awake, wd_start, wd_timeout, supply_fail, go_exit;

  assign cmd_addr = last_cmd[qss_pkg::ADDR_HI:qss_pkg::ADDR_LO];
  assign awake = s_init | s_wake | (|s_dir);
  assign wd_start = (s_init & ~p_init) | (s_wake & ~p_wake) | (|(s_dir & ~p_dir));
  assign wd_timeout = wd_run & s_strap & (wd_cnt == WDT_COUNT - 1);
  assign supply_fail = s_vdd & vdd_en;
  assign go_exit = cmd_valid & last_cmd[qss_pkg::WD_BIT] & ~s_vdd;

  always_comb
  begin
    next_mode = mode;
    next_on_bits = on_bits;
    next_dir_dis = dir_dis;
    next_sense_cfg = sense_cfg;
    next_vdd_en = vdd_en;
    next_pwm_en = pwm_en;
    next_duty = duty;
    next_wd_last = wd_last;
    next_wd_run = wd_run;
    next_wd_fired = wd_fired;
    next_wd_cnt = wd_cnt;
    next_fault_lat = fault_lat;
    next_pwm_cnt = pwm_cnt;
    // External PWM clock counted on input zero rising edges
    if (s_dir[0] && !p_dir[0])
    begin
      next_pwm_cnt = pwm_cnt + 7'h01;
    end
    // Serial writes land in the addressed register in normal mode only
    if (cmd_valid && mode == qss_pkg::QSS_NORMAL)
    begin
      if (cmd_addr == qss_pkg::SA_OUT_ON)
      begin
        next_on_bits = last_cmd[3:0];
      end
      else if (cmd_addr == qss_pkg::SA_DIR_DIS)
      begin
        next_dir_dis = last_cmd[3:0];
      end
      else if (cmd_addr == qss_pkg::SA_SENSE)
      begin
        next_sense_cfg = last_cmd[3:0];
      end
      else if (cmd_addr == qss_pkg::SA_CONTROL)
      begin
        next_vdd_en = last_cmd[qss_pkg::CTRL_VDD_EN_BIT];
        next_pwm_en = last_cmd[qss_pkg::CTRL_PWM_EN_BIT];
      end
      else if (cmd_addr == qss_pkg::SA_DUTY)
      begin
        next_duty = last_cmd[6:0];
      end
    end
    // Watchdog refresh on a toggled bit, restart on wake edges
    if (cmd_valid)
    begin
      next_wd_last = last_cmd[qss_pkg::WD_BIT];
    end
    if (wd_start || (cmd_valid && last_cmd[qss_pkg::WD_BIT] != wd_last))
    begin
      next_wd_cnt = 32'h0;
      next_wd_run = next_wd_run | wd_start;
    end
    else if (wd_run && s_strap && !wd_timeout)
    begin
      next_wd_cnt = wd_cnt + 32'h1;
    end
    // Mode transitions
    case (mode)
      qss_pkg::QSS_SLEEP:
      begin
        if (awake)
        begin
          next_mode = qss_pkg::QSS_NORMAL;
        end
      end
      qss_pkg::QSS_NORMAL:
      begin
        if (!awake)
        begin
          next_mode = qss_pkg::QSS_SLEEP;
        end
        else if (wd_timeout || supply_fail)
        begin
          next_mode = qss_pkg::QSS_FAILSAFE;
          next_wd_fired = wd_timeout;
        end
      end
      qss_pkg::QSS_FAILSAFE:
      begin
        if (!awake)
        begin
          next_mode = qss_pkg::QSS_SLEEP;
        end
        else if (go_exit || (wd_fired && !s_strap && !supply_fail))
        begin
          next_mode = qss_pkg::QSS_NORMAL;
          next_wd_fired = 1'b0;
          next_wd_cnt = 32'h0;
        end
      end
      default:
      begin
        next_mode = qss_pkg::QSS_SLEEP;
      end
    endcase
    // Fail-safe and sleep hold configuration at defaults; fail-safe keeps vdd_en
    if (next_mode != qss_pkg::QSS_NORMAL)
    begin
      next_on_bits = qss_pkg::RST_NIBBLE;
      next_dir_dis = qss_pkg::RST_NIBBLE;
      next_sense_cfg = qss_pkg::RST_NIBBLE;
      next_pwm_en = 1'b0;
      next_duty = qss_pkg::RST_DUTY;
      next_vdd_en = (mode == qss_pkg::QSS_SLEEP) ? 1'b0 : vdd_en;
    end
    // Faults: a new fault beats the exit clear in the same cycle
    next_fault_lat = (go_exit && mode == qss_pkg::QSS_FAILSAFE) ? 4'h0 : fault_lat;
    next_fault_lat = next_fault_lat | (s_fault & ~fault_mask);
    // Init low wipes configuration and faults
    if (!s_init)
    begin
      next_on_bits = qss_pkg::RST_NIBBLE;
      next_dir_dis = qss_pkg::RST_NIBBLE;
      next_sense_cfg = qss_pkg::RST_NIBBLE;
      next_vdd_en = 1'b0;
      next_pwm_en = 1'b0;
      next_duty = qss_pkg::RST_DUTY;
      next_fault_lat = 4'h0;
      next_wd_run = 1'b0;
      next_wd_fired = 1'b0;
      next_wd_cnt = 32'h0;
    end
    // Lamp drive per mode
    case (mode)
      qss_pkg::QSS_NORMAL:
      begin
        if (pwm_en)
        begin
          next_lamps = on_bits & {4{pwm_cnt <= duty}};
        end
        else
        begin
          next_lamps = on_bits | (s_dir & ~dir_dis);
        end
      end
      qss_pkg::QSS_FAILSAFE:
      begin
        next_lamps = s_dir;
      end
      default:
      begin
        next_lamps = 4'h0;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      mode <= qss_pkg::QSS_SLEEP;
      on_bits <= qss_pkg::RST_NIBBLE;
      dir_dis <= qss_pkg::RST_NIBBLE;
      sense_cfg <= qss_pkg::RST_NIBBLE;
      vdd_en <= 1'b0;
      pwm_en <= 1'b0;
      duty <= qss_pkg::RST_DUTY;
      pwm_cnt <= 7'h00;
      wd_last <= 1'b0;
      wd_run <= 1'b0;
      wd_fired <= 1'b0;
      wd_cnt <= 32'h0;
      fault_lat <= 4'h0;
      lamp_outputs <= 4'h0;
    end
    else
    begin
      mode <= next_mode;
      on_bits <= next_on_bits;
      dir_dis <= next_dir_dis;
      sense_cfg <= next_sense_cfg;
      vdd_en <= next_vdd_en;
      pwm_en <= next_pwm_en;
      duty <= next_duty;
      pwm_cnt <= next_pwm_cnt;
      wd_last <= next_wd_last;
      wd_run <= next_wd_run;
      wd_fired <= next_wd_fired;
      wd_cnt <= next_wd_cnt;
      fault_lat <= next_fault_lat;
      lamp_outputs <= next_lamps;
    end
  end

  // Open-drain flag: only ever pulls low, enable marks a fault
  assign fault_flag_n_out = 1'b0;
  assign fault_flag_n_oe = |fault_lat;
  // Sense path follows configuration; disabled in sleep
  assign sense_channel = sense_cfg[1:0];
  assign sense_temp = sense_cfg[qss_pkg::SENSE_TEMP_BIT];
  assign sense_output_oe = ~sense_cfg[qss_pkg::SENSE_HIZ_BIT] & (mode != qss_pkg::QSS_SLEEP);

  // Status snapshot loaded at frame start
  always_comb
  begin
    status_word = qss_pkg::RST_WORD;
    status_word[qss_pkg::ST_NORMAL] = (mode == qss_pkg::QSS_NORMAL);
    status_word[qss_pkg::ST_FAILSAFE] = (mode == qss_pkg::QSS_FAILSAFE);
    status_word[qss_pkg::ST_WD_EN] = s_strap;
    status_word[qss_pkg::ST_VDD_FAIL] = s_vdd;
    status_word[qss_pkg::ST_FAULT_LO +: 4] = fault_lat;
    status_word[qss_pkg::ST_DIRECT_LO +: 4] = s_dir;
    status_word[qss_pkg::ST_LAMP_LO +: 4] = lamp_outputs;
  end

  // ==========================================================================
  // AHB-Lite register slave, zero wait states
  logic dp_write, next_dp_write;
  logic [7:0] dp_addr, next_dp_addr;
  logic rd_mirror, next_rd_mirror;
  logic [31:0] rd_hold, next_rd_hold;
  logic [3:0] next_fault_mask;
  logic [15:0] mirror_q;
  logic addr_phase;

  assign addr_phase = hsel & hready & htrans[1];

  always_comb
  begin
    next_dp_write = addr_phase & hwrite;
    next_dp_addr = haddr[7:0];
    next_rd_mirror = 1'b0;
    next_rd_hold = 32'h0000_0000;
    next_fault_mask = fault_mask;
    // Software mask steers which fault inputs may latch
    if (dp_write && dp_addr == qss_pkg::RA_FAULT_MASK)
    begin
      next_fault_mask = hwdata[3:0];
    end
    if (addr_phase && !hwrite)
    begin
      if (haddr[7:0] == qss_pkg::RA_STATUS)
      begin
        next_rd_hold = {16'h0000, status_word};
      end
      else if (haddr[7:0] == qss_pkg::RA_FAULT_MASK)
      begin
        next_rd_hold = {28'h0000000, next_fault_mask};
      end
      else if (haddr[7:0] == qss_pkg::RA_LAST_CMD)
      begin
        next_rd_hold = {16'h0000, last_cmd};
      end
      else if (haddr[7] == qss_pkg::RA_MIRROR[7])
      begin
        next_rd_mirror = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      rd_mirror <= 1'b0;
      rd_hold <= 32'h0000_0000;
      fault_mask <= qss_pkg::RST_FAULT_MASK;
    end
    else
    begin
      dp_write <= next_dp_write;
      dp_addr <= next_dp_addr;
      rd_mirror <= next_rd_mirror;
      rd_hold <= next_rd_hold;
      fault_mask <= next_fault_mask;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_mirror ? {16'h0000, mirror_q} : rd_hold;

  // Every accepted serial word is kept by address for readback
  qss_mirror_mem u_mirror
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(cmd_valid),
    .wr_addr(cmd_addr),
    .wr_data(last_cmd),
    .rd_addr(haddr[6:2]),
    .rd_data(mirror_q)
  );

endmodule : qss_spi_ctrl

// file: verif/qss_master.sv
// Behavioural serial master that frames words for the quad switch
`timescale 1ns/100ps
module qss_master
#(
  parameter int HALF = 4
)
(
  // Clock
  input wire logic mclk,
  // Serial pins
  input wire logic so,
  output logic sclk,
  output logic select_n,
  output logic si
);
  // ==========================================================================
  // Idle: clock low, select high
  initial
  begin
    sclk = 1'b0;
    select_n = 1'b1;
    si = 1'b0;
  end

  // One frame of nbits; a short count exercises the length check
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge mclk);
    select_n <= 1'b0; // Clock is low at this edge
    repeat (8) @(posedge mclk);
    for (int i = 0; i < nbits; i++)
    begin
      sclk <= 1'b1;
      si <= tx[15 - i]; // MSB first, settled long before the fall
      repeat (HALF) @(posedge mclk);
      sclk <= 1'b0;
      repeat (2) @(posedge mclk);
      rx = {rx[14:0], so}; // Bit read in the low phase after the fall
      repeat (HALF - 2) @(posedge mclk);
    end
    repeat (HALF) @(posedge mclk);
    select_n <= 1'b1; // Clock low again before select rises
    si <= ~si; // Released line does not keep its last level
    repeat (8) @(posedge mclk);
  endtask : xfer
endmodule : qss_master

// file: verif/qss_spi_ctrl_asserts.sv
// Concurrent checks on the ports of the quad switch serial block
`timescale 1ns/100ps
module qss_spi_ctrl_asserts
#(
  parameter int WDT_COUNT = 200
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // Serial link
  input wire logic sclk,
  input wire logic select_n,
  input wire logic so_out,
  input wire logic so_oe,
  // Pins
  input wire logic init_n,
  input wire logic wake,
  input wire logic failsafe_strap,
  input wire logic [3:0] direct_inputs,
  input wire logic [3:0] fault_in,
  input wire logic [3:0] lamp_outputs,
  input wire logic fault_flag_n_out,
  input wire logic fault_flag_n_oe,
  input wire logic sense_output_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Cycles since a raw clock rise or select fall; saturates
  logic sclk_q, sel_q, rd_req;
  logic [3:0] since_evt, next_since_evt;
  assign rd_req = hsel && hready && htrans[1] && !hwrite;
  always_comb
  begin
    if ((sclk && !sclk_q) || (!select_n && sel_q))
      next_since_evt = 4'h0;
    else
      next_since_evt = (since_evt == 4'hF) ? 4'hF : since_evt + 4'h1;
  end
  always_ff @(posedge mclk)
  begin
    sclk_q <= sclk;
    sel_q <= select_n;
    since_evt <= rst_n ? next_since_evt : 4'hF;
  end

  // ==========================================================================
  // Assertions
  a_so_off_idle: assert property ((select_n)[*6] |-> !so_oe)
    else $error("serial output driven while deselected");
  a_so_on_frame: assert property ($fell(select_n) |-> ##[1:5] so_oe)
    else $error("serial output not driven in frame");
  a_so_rise_shift: assert property (so_oe && $past(so_oe) && $changed(so_out)
    |-> since_evt <= 4'h5)
    else $error("serial output moved away from a clock rise");
  a_flag_open_drain: assert property (fault_flag_n_oe |-> !fault_flag_n_out)
    else $error("fault flag drives high");
  a_init_clears: assert property ((!init_n && !wake && fault_in == 4'h0
    && direct_inputs == 4'h0)[*8] |-> lamp_outputs == 4'h0 && !fault_flag_n_oe)
    else $error("init low left lamps or faults set");
  a_unmapped_zero: assert property (rd_req && haddr == 32'h40 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus wait or error response");
  a_status_lamps: assert property (rd_req && haddr == 32'h0
    && lamp_outputs == $past(lamp_outputs, 3)
    |=> hrdata[3:0] == $past(lamp_outputs) && hrdata[31:16] == 16'h0)
    else $error("status lamp field wrong");
  a_strap_status: assert property (rd_req && haddr == 32'h0
    && failsafe_strap == $past(failsafe_strap, 6) |=> hrdata[13] == $past(failsafe_strap))
    else $error("status strap bit wrong");

  // Main scenarios
  c_frame: cover property ($fell(select_n));
  c_fault: cover property ($rose(fault_flag_n_oe));
  c_sense_off: cover property ($fell(sense_output_oe));
endmodule : qss_spi_ctrl_asserts

bind qss_spi_ctrl qss_spi_ctrl_asserts #(.WDT_COUNT(WDT_COUNT)) u_chk (.mclk(mclk),
  .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sclk(sclk),
  .select_n(select_n), .so_out(so_out), .so_oe(so_oe), .init_n(init_n), .wake(wake),
  .failsafe_strap(failsafe_strap), .direct_inputs(direct_inputs), .fault_in(fault_in),
  .lamp_outputs(lamp_outputs), .fault_flag_n_out(fault_flag_n_out),
  .fault_flag_n_oe(fault_flag_n_oe), .sense_output_oe(sense_output_oe));

// file: verif/qss_spi_ctrl_test.sv
// Self-checking bench for the quad switch serial control block
`timescale 1ns/100ps
module qss_spi_ctrl_test;
  // ==========================================================================
  // Signals; watchdog count shortened so a timeout fits the run
  localparam int WDT = 1000;
  logic mclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, wake = 1'b0;
  logic init_n = 1'b1, strap = 1'b0, vdd_fail = 1'b0, so_float = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [3:0] direct = 4'h0, fault_in = 4'h0, lamps;
  logic [1:0] sense_channel;
  logic hreadyout, hresp, sclk, select_n, si, so_out, so_oe, so_wire;
  logic flag_out, flag_oe, sense_temp, sense_oe;
  logic [15:0] rx;
  int fail_count = 0, total_checks = 0, cycles = 0;

  always #5 mclk = ~mclk;
  // Undriven output shows a changing level, never a held one
  always @(posedge mclk) so_float <= ~so_float;
  assign so_wire = so_oe ? so_out : so_float;

  qss_spi_ctrl #(.WDT_COUNT(WDT)) uut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .sclk(sclk), .select_n(select_n), .si(si), .so_out(so_out), .so_oe(so_oe),
    .init_n(init_n), .wake(wake), .failsafe_strap(strap), .vdd_fail(vdd_fail),
    .direct_inputs(direct), .fault_in(fault_in), .lamp_outputs(lamps),
    .fault_flag_n_out(flag_out), .fault_flag_n_oe(flag_oe),
    .sense_channel(sense_channel), .sense_temp(sense_temp), .sense_output_oe(sense_oe));
  qss_master m0 (.mclk(mclk), .so(so_wire), .sclk(sclk), .select_n(select_n), .si(si));

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  function automatic logic [15:0] cmd(input logic wd, input logic [4:0] a,
    input logic [9:0] v);
    return {wd, a, v};
  endfunction : cmd

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // ==========================================================================
  // Scenarios
  task automatic t_frames();
    ahb(1'b0, 32'h0, 32'h0, d);
    check(d, 32'h8000);
    m0.xfer(cmd(1'b0, qss_pkg::SA_OUT_ON, 10'h00A), 16, rx);
    check(lamps, 4'hA);
    ahb(1'b0, 32'h80, 32'h0, d);
    check(d, 32'h000A);
    m0.xfer(cmd(1'b0, qss_pkg::SA_OUT_ON, 10'h005), 15, rx);
    check(rx, 16'h4005);
    check(lamps, 4'hA);
    m0.xfer(cmd(1'b0, qss_pkg::SA_OUT_ON, 10'h000), 16, rx);
    check(rx, 16'h800A);
    check(lamps, 4'h0);
  endtask : t_frames

  task automatic t_direct();
    direct <= 4'h5;
    repeat (8) @(posedge mclk);
    check(lamps, 4'h5);
    m0.xfer(cmd(1'b0, qss_pkg::SA_DIR_DIS, 10'h004), 16, rx);
    check(rx, 16'h8055);
    check(lamps, 4'h1);
    m0.xfer(cmd(1'b0, qss_pkg::SA_DIR_DIS, 10'h000), 16, rx);
    direct <= 4'h0;
  endtask : t_direct

  task automatic t_faults();
    ahb(1'b1, 32'h4, 32'h2, d);
    ahb(1'b0, 32'h4, 32'h0, d);
    check(d, 32'h2);
    fault_in <= 4'h2;
    repeat (8) @(posedge mclk);
    check(flag_oe, 1'b0);
    fault_in <= 4'h6;
    repeat (8) @(posedge mclk);
    fault_in <= 4'h0;
    repeat (8) @(posedge mclk);
    check({flag_oe, flag_out}, 2'b10);
    ahb(1'b0, 32'h0, 32'h0, d);
    check(d[11:8], 4'h4);
  endtask : t_faults

  task automatic t_sense();
    m0.xfer(cmd(1'b0, qss_pkg::SA_SENSE, 10'h006), 16, rx);
    check({sense_oe, sense_temp, sense_channel}, 4'hE);
    m0.xfer(cmd(1'b0, qss_pkg::SA_SENSE, 10'h00E), 16, rx);
    check(sense_oe, 1'b0);
  endtask : t_sense

  task automatic t_watchdog();
    init_n <= 1'b0;
    strap <= 1'b1;
    repeat (12) @(posedge mclk);
    check({lamps, flag_oe}, 5'h00);
    init_n <= 1'b1;
    repeat (600) @(posedge mclk);
    m0.xfer(cmd(1'b1, 5'h1F, 10'h000), 16, rx);
    repeat (600) @(posedge mclk);
    ahb(1'b0, 32'h0, 32'h0, d);
    check(d[15:13], 3'b101);
    repeat (600) @(posedge mclk);
    ahb(1'b0, 32'h0, 32'h0, d);
    check(d[15:14], 2'b01);
    direct <= 4'h9;
    m0.xfer(cmd(1'b0, qss_pkg::SA_OUT_ON, 10'h006), 16, rx);
    check(lamps, 4'h9);
    m0.xfer(cmd(1'b1, 5'h1F, 10'h000), 16, rx);
    strap <= 1'b0;
    direct <= 4'h0;
    ahb(1'b0, 32'h0, 32'h0, d);
    check(d[15:14], 2'b10);
  endtask : t_watchdog

  task automatic t_supply();
    m0.xfer(cmd(1'b0, qss_pkg::SA_CONTROL, 10'h001), 16, rx);
    vdd_fail <= 1'b1;
    direct <= 4'h2;
    repeat (10) @(posedge mclk);
    check(lamps, 4'h2);
    ahb(1'b0, 32'h0, 32'h0, d);
    check(d[15:12], 4'h5);
    vdd_fail <= 1'b0;
    m0.xfer(cmd(1'b1, 5'h1F, 10'h000), 16, rx);
    ahb(1'b0, 32'h0, 32'h0, d);
    check(d[15:14], 2'b10);
  endtask : t_supply

  // Hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      final_report();
    end
  end

  // Main sequence after two cycles of reset
  initial
  begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    check({so_oe, lamps, flag_oe, sense_oe}, 7'h01);
    ahb(1'b0, 32'h40, 32'h0, d);
    check(d, 32'h0);
    t_frames();
    t_direct();
    t_faults();
    t_sense();
    t_watchdog();
    t_supply();
    final_report();
  end
endmodule : qss_spi_ctrl_test
